// File: hdl/rirq_top.sv
// rirq_top: interrupt status, mask and collision position logic of the reader
`timescale 1ns/1ps
module rirq_top
    import rirq_pkg::*;
(
    input wire logic clk,                // system clock, 125 MHz
    input wire logic rstn,               // power-on reset, async, active low
    input wire logic chip_en,            // chip enable pin, low holds reset values except in phase, decoder_enable and the read port
    input wire logic [7:0] reg_addr,     // register port address
    input wire logic [7:0] reg_wdata,    // register port write data
    input wire logic reg_wr,             // register write strobe, one cycle
    input wire logic reg_rd,             // register read strobe, one cycle
    output logic [7:0] reg_rdata,        // read data, valid with reg_rdata_valid
    output logic reg_rdata_valid,        // one-cycle read answer
    input wire logic tx_active,          // transmit phase in progress
    input wire logic rx_active,          // receive phase in progress, from sof
    input wire logic fifo_level_hit,     // fifo reached high or low level, pulse
    input wire logic crc_err,            // receive crc failure, pulse
    input wire logic parity_err,         // character parity failure, pulse
    input wire logic framing_err,        // byte framing failure, pulse
    input wire logic eof_err,            // end-of-frame failure, pulse
    input wire logic collision_hit,      // collision seen outside 106 kbps counting
    input wire logic [3:0] col_hits,     // detections within current bit period
    input wire logic bit_period_end,     // end of one 106 kbps bit period, pulse
    input wire logic rate_106k,          // type A running at 106 kbps
    input wire logic col_thresh_seven,   // collision threshold 7 instead of 6
    input wire logic noresp_timeout,     // no-response wait time expired, pulse
    input wire logic mode_type_a,        // type A proximity protocol selected
    input wire logic mode_vicinity,      // vicinity protocol selected
    input wire logic single_subcarrier,  // vicinity single subcarrier selected
    input wire logic err_pos_valid,      // collision or error position valid, pulse
    input wire logic [9:0] err_pos,      // collision or error bit position
    output logic irq,                    // interrupt request, active high
    output logic decoder_enable          // receive decoder enabled
);
    // status flag bank carrier: set and clear in, flag values out
    rirq_flag_if #(.W(8)) flags ();

    // phase tracking
    rirq_phase_t phase;
    rirq_phase_t next_phase;

    // host-visible register state
    logic [7:0] mask_en;
    logic [1:0] col_pos_hi;
    logic [7:0] col_pos_lo;
    logic no_rx_crc;

    // cause assembly
    logic [7:0] rx_pend;
    logic [7:0] raw_ev;
    logic [7:0] allow;
    logic [7:0] status_set;
    logic [7:0] irq_en;
    logic [3:0] col_thresh;
    logic col_ev;

    // phase edges
    logic tx_start;
    logic rx_start;
    logic tx_end;
    logic rx_end;
    logic phase_end;

    // register port strobes and clear reasons
    logic status_clr;
    logic status_rd;
    logic mask_rd;
    logic colpos_rd;
    logic proto_wr;
    logic mask_wr;

    // request line raise term
    logic irq_raise;

    // register port decode
    assign status_rd = reg_rd && (reg_addr == ADDR_STATUS);
    assign mask_rd = reg_rd && (reg_addr == ADDR_MASK);
    assign colpos_rd = reg_rd && (reg_addr == ADDR_COL_POS);
    assign proto_wr = reg_wr && (reg_addr == ADDR_PROTO_CTRL);
    assign mask_wr = reg_wr && (reg_addr == ADDR_MASK);

    // every reason for clearing the status in one term
    // (enable pin low, protocol control write, acknowledging status read)
    assign status_clr = !chip_en || proto_wr || status_rd;

    // phase tracker, transmit takes precedence over receive
    always_comb begin
        if (tx_active) begin
            next_phase = RIRQ_PH_TX;
        end else if (rx_active) begin
            next_phase = RIRQ_PH_RX;
        end else begin
            next_phase = RIRQ_PH_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase <= RIRQ_PH_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // phase edges
    assign tx_start = (next_phase == RIRQ_PH_TX) && (phase != RIRQ_PH_TX);
    assign rx_start = (next_phase == RIRQ_PH_RX) && (phase != RIRQ_PH_RX);
    assign tx_end = (phase == RIRQ_PH_TX) && (next_phase != RIRQ_PH_TX);
    assign rx_end = (phase == RIRQ_PH_RX) && (next_phase != RIRQ_PH_RX);
    assign phase_end = tx_end || rx_end;

    // collision detection per protocol and rate
    assign col_thresh = col_thresh_seven ? COL_THRESH_HIGH : COL_THRESH_LOW;
    always_comb begin
        col_ev = 1'b0;
        if (mode_type_a) begin
            if (rate_106k) begin
                col_ev = bit_period_end && (col_hits > col_thresh);
            end else begin
                col_ev = collision_hit;
            end
        end else if (mode_vicinity && single_subcarrier) begin
            col_ev = collision_hit;
        end
    end

    // raw causes before phase gating
    always_comb begin
        raw_ev = 8'h00;
        raw_ev[ST_TX] = tx_start;
        raw_ev[ST_RX] = rx_start;
        raw_ev[ST_FIFO] = fifo_level_hit;
        raw_ev[ST_CRC] = crc_err && !no_rx_crc;
        raw_ev[ST_PARITY] = parity_err && mode_type_a;
        raw_ev[ST_FRAMING] = framing_err || eof_err;
        raw_ev[ST_COL] = col_ev;
        raw_ev[ST_NORESP] = noresp_timeout && mode_vicinity;
    end

    // which bits may change in the current phase
    always_comb begin
        allow = 8'hFF;  // idle lets every cause through
        unique case (next_phase)
            RIRQ_PH_TX: allow = TX_CHANGE_MASK;
            RIRQ_PH_RX: allow = RX_CHANGE_MASK;
            RIRQ_PH_IDLE: allow = 8'hFF;
        endcase
    end

    // errors found during receive wait here and post at receive end; the
    // host must not see an error before the frame is over, and dropping it
    // would lose the reason for a failed frame
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_pend <= STATUS_RESET;
        end else if (!chip_en || proto_wr || rx_end) begin
            rx_pend <= STATUS_RESET;
        end else if (next_phase == RIRQ_PH_RX) begin
            rx_pend <= rx_pend | (raw_ev & RX_ERR_MASK);
        end
    end

    // flag bank inputs, masked causes are still recorded
    assign status_set = (raw_ev & allow) | (rx_end ? rx_pend : STATUS_RESET);
    assign flags.set = chip_en ? status_set : STATUS_RESET;
    assign flags.clr = status_clr;

    // sticky status flags, a set beats a clear
    rirq_flags #(.W(8)) u_flags (
        .clk (clk),
        .rstn (rstn),
        .f (flags)
    );

    // interrupt enables: phase flags always, others from the mask
    assign irq_en = PHASE_FLAG_EN | {2'b00, mask_en[MASK_EN_MSB:0]};

    // line rises at phase end for any enabled pending cause, or at once
    // for an enabled cause outside receive (fifo refill, no response)
    always_comb begin
        irq_raise = 1'b0;
        if (phase_end) begin
            irq_raise = |((flags.q | status_set) & irq_en);
        end else if (next_phase != RIRQ_PH_RX) begin
            irq_raise = |(status_set & irq_en & ~PHASE_FLAG_EN);
        end
    end

    // interrupt line: a new request wins over a clear in the same cycle,
    // so a cause landing in the acknowledging read cycle is not lost;
    // chip enable low still forces the line down
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else if (!chip_en) begin
            irq <= 1'b0;
        end else if (irq_raise) begin
            irq <= 1'b1;
        end else if (status_clr) begin
            irq <= 1'b0;
        end
    end

    // enable bits of the mask register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_en <= MASK_RESET;
        end else if (!chip_en) begin
            mask_en <= MASK_RESET;
        end else if (mask_wr) begin
            mask_en <= {2'b00, reg_wdata[MASK_EN_MSB:0]};
        end
    end

    // collision position bits 9..8, read to clear, capture wins over clear
    // so a fresh position is never lost to a read in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            col_pos_hi <= MASK_RESET[7:MASK_COL_LSB];
        end else if (!chip_en) begin
            col_pos_hi <= MASK_RESET[7:MASK_COL_LSB];
        end else if (err_pos_valid) begin
            col_pos_hi <= err_pos[COL_POS_W-1:8];
        end else if (mask_rd) begin
            col_pos_hi <= 2'b00;
        end
    end

    // collision or error position bits 7..0, read to clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            col_pos_lo <= COL_POS_RESET;
        end else if (!chip_en) begin
            col_pos_lo <= COL_POS_RESET;
        end else if (err_pos_valid) begin
            col_pos_lo <= err_pos[7:0];
        end else if (colpos_rd) begin
            col_pos_lo <= COL_POS_RESET;
        end
    end

    // shadow of the no-rx-crc option, taken from protocol control writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            no_rx_crc <= NO_RX_CRC_RESET;
        end else if (!chip_en) begin
            no_rx_crc <= NO_RX_CRC_RESET;
        end else if (proto_wr) begin
            no_rx_crc <= reg_wdata[PROTO_NO_RX_CRC];
        end
    end

    // read answer, value before any read-to-clear takes effect
    // reads of write-only or unknown addresses answer zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    ADDR_STATUS: reg_rdata <= flags.q;
                    ADDR_MASK: reg_rdata <= {col_pos_hi, mask_en[MASK_EN_MSB:0]};
                    ADDR_COL_POS: reg_rdata <= col_pos_lo;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // decoder is switched off for the whole transmit phase
    // it follows the transmit level one cycle late, as a registered output
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            decoder_enable <= 1'b1;
        end else begin
            decoder_enable <= !tx_active;
        end
    end
endmodule

// File: hdl/rirq_pkg.sv
// rirq_pkg: constants for the reader interrupt status and mask block
package rirq_pkg;
    // register offsets on the register port
    localparam logic [7:0] ADDR_PROTO_CTRL = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h0D;
    localparam logic [7:0] ADDR_COL_POS = 8'h0E;

    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h3E;
    localparam logic [7:0] COL_POS_RESET = 8'h00;
    localparam logic NO_RX_CRC_RESET = 1'b0;

    // status bit positions
    localparam int ST_TX = 7;
    localparam int ST_RX = 6;
    localparam int ST_FIFO = 5;
    localparam int ST_CRC = 4;
    localparam int ST_PARITY = 3;
    localparam int ST_FRAMING = 2;
    localparam int ST_COL = 1;
    localparam int ST_NORESP = 0;

    // mask register fields: enables in 5:0, collision position bits 9:8 in 7:6
    localparam int MASK_COL_LSB = 6;
    localparam int MASK_EN_MSB = 5;
    localparam int COL_POS_W = 10;

    // no-rx-crc option bit in the protocol control register
    localparam int PROTO_NO_RX_CRC = 7;

    // which status bits may change in each phase
    localparam logic [7:0] TX_CHANGE_MASK = 8'hA0;
    localparam logic [7:0] RX_CHANGE_MASK = 8'h40;
    // error causes held back while receiving and posted at its end
    localparam logic [7:0] RX_ERR_MASK = 8'h1E;
    // transmit and receive flags always take part in the end-of-phase request
    localparam logic [7:0] PHASE_FLAG_EN = 8'hC0;

    // collision detection thresholds at 106 kbps
    localparam logic [3:0] COL_THRESH_LOW = 4'h6;
    localparam logic [3:0] COL_THRESH_HIGH = 4'h7;

    // transfer phase tracker
    typedef enum logic [1:0] {
        RIRQ_PH_IDLE = 2'b00,
        RIRQ_PH_TX = 2'b01,
        RIRQ_PH_RX = 2'b10
    } rirq_phase_t;
endpackage

// File: hdl/rirq_flag_if.sv
// rirq_flag_if: set, clear and value lines of a sticky flag bank
`timescale 1ns/1ps
interface rirq_flag_if #(parameter int W = 8);
    logic [W-1:0] set;
    logic clr;
    logic [W-1:0] q;
    modport bank (input set, input clr, output q);
    modport ctrl (output set, output clr, input q);
endinterface

// File: hdl/rirq_flags.sv
// rirq_flags: bank of sticky flags where a set beats a clear
`timescale 1ns/1ps
module rirq_flags
    import rirq_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clk,   // system clock
    input wire logic rstn,  // async reset, active low
    rirq_flag_if.bank f     // set, clear and flag value
);
    logic [W-1:0] flag;

    // a flag set in the clearing cycle survives the clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag <= '0;
        end else begin
            flag <= f.set | (flag & ~{W{f.clr}});
        end
    end

    assign f.q = flag;
endmodule

// File: bench/rirq_checker.sv
// rirq_checker: port-level assertions for rirq_top
`timescale 1ns/1ps
module rirq_checker
    import rirq_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rstn, // reset
    input wire logic chip_en, // enable pin
    input wire logic [7:0] reg_addr, // address
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic reg_rdata_valid, // read answer
    input wire logic tx_active, // transmit
    input wire logic rx_active, // receive
    input wire logic fifo_level_hit, // fifo
    input wire logic crc_err, // crc
    input wire logic parity_err, // parity
    input wire logic framing_err, // framing
    input wire logic eof_err, // eof
    input wire logic collision_hit, // collision
    input wire logic noresp_timeout, // no response
    input wire logic bit_period_end, // bit period
    input wire logic irq, // request line
    input wire logic decoder_enable // decoder on
);
    logic quiet;
    // no event pulse in this cycle
    assign quiet = !(fifo_level_hit | crc_err | parity_err | framing_err | eof_err | collision_hit
        | noresp_timeout | bit_period_end);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_read_answer: assert property (reg_rd |=> reg_rdata_valid)
        else $error("read without answer");
    a_valid_alone: assert property (!reg_rd |=> !reg_rdata_valid)
        else $error("answer without read");
    a_enable_low_clear: assert property (!chip_en |=> !irq)
        else $error("line up after enable low");
    a_proto_write_clear: assert property (reg_wr && reg_addr == ADDR_PROTO_CTRL && quiet && !tx_active
        && !rx_active && !$past(tx_active) && !$past(rx_active) |=> !irq)
        else $error("line up after control write");
    a_ack_read_clear: assert property (reg_rd && reg_addr == ADDR_STATUS && quiet && !tx_active
        && !rx_active && !$past(tx_active) && !$past(rx_active) |=> !irq)
        else $error("line up after status read");
    a_tx_silent: assert property (tx_active && $past(tx_active) && !fifo_level_hit && !irq |=> !irq)
        else $error("line rose inside transmit");
    a_rx_silent: assert property (rx_active && !tx_active && $past(rx_active && !tx_active) && !irq
        |=> !irq)
        else $error("line rose inside receive");
    a_tx_end_raise: assert property ($fell(tx_active) && chip_en && !rx_active |=> irq)
        else $error("no line at transmit end");
    a_rx_end_raise: assert property ($fell(rx_active) && !tx_active && !$past(tx_active) && chip_en
        |=> irq)
        else $error("no line at receive end");
    a_decoder_off: assert property (tx_active |=> !decoder_enable)
        else $error("decoder on in transmit");
    c_tx_end: cover property ($fell(tx_active) ##1 irq);
    c_read: cover property (reg_rdata_valid);
    c_enable_low: cover property (!chip_en);
endmodule

bind rirq_top rirq_checker chk_u (.*);

// File: bench/rirq_host.sv
// rirq_host: host controller model on the register port
`timescale 1ns/1ps
module rirq_host (
    input wire logic clk, // clock
    output logic [7:0] reg_addr, // address
    output logic [7:0] reg_wdata, // write data
    output logic reg_wr, // write strobe
    output logic reg_rd // read strobe
);
    // idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one strobe over one rising edge; unused lines then flip
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask
    // status read also acknowledges the interrupt
    task automatic rd(input logic [7:0] a);
        acc(1'b0, a, 8'h00);
    endtask
endmodule

// File: bench/tb.sv
// tb: self-checking bench for the reader interrupt block
`timescale 1ns/1ps
module tb;
    import rirq_pkg::*;
    logic clk = 0, rstn = 0, chip_en = 1, tx_active = 0, rx_active = 0, rate_106k = 0;
    logic col_thresh_seven = 0, mode_type_a = 0, mode_vicinity = 0, single_subcarrier = 0;
    logic err_pos_valid = 0, reg_wr, reg_rd, reg_rdata_valid, irq, decoder_enable;
    logic [9:0] err_pos = '0;
    logic [3:0] col_hits = '0;
    logic [7:0] evt = '0, reg_addr, reg_wdata, reg_rdata;
    logic fifo_level_hit, crc_err, parity_err, framing_err, eof_err, collision_hit, noresp_timeout;
    logic bit_period_end;
    logic [7:0] exp_q[$];
    logic [31:0] lfsr = 32'h00012BFC;
    int n_fail = 0, samples_checked = 0;
    assign {bit_period_end, noresp_timeout, collision_hit, eof_err, framing_err, parity_err, crc_err,
        fifo_level_hit} = evt;
    // clock
    always #4 clk = ~clk;
    rirq_top dut_u (.*);
    rirq_host host_u (.*);
    // lfsr step
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one-cycle event pulse
    task automatic ev(input logic [7:0] v);
        @(negedge clk) evt = v;
        @(negedge clk) evt = '0;
    endtask
    // value compare
    task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    // request line compare
    task automatic chk_irq(input logic e);
        cmp({7'h00, irq}, {7'h00, e}, "irq");
    endtask
    // note expected data, then read
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.rd(a);
    endtask
    // verdict
    task automatic summarize();
        // a read that was never answered counts as a mismatch
        if (exp_q.size() != 0) begin
            n_fail++;
            $display("wrong value at %0t: %0d reads unanswered", $time, exp_q.size());
        end
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // match each read answer with the oldest note, away from the launching edge
    always @(negedge clk) begin
        if (reg_rdata_valid === 1'b1) begin
            cmp(reg_rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX, "read");
        end
    end
    // watchdog
    initial begin
        #50000;
        n_fail++;
        summarize();
    end
    // main sequence
    initial begin
        repeat (6) @(negedge clk);
        rstn = 1;
        rd(ADDR_STATUS, STATUS_RESET);
        rd(ADDR_MASK, MASK_RESET);
        rd(8'h20, 8'h00);
        ev(8'h01);
        chk_irq(1'b1);
        rd(ADDR_STATUS, 8'h20);
        chk_irq(1'b0);
        host_u.wr(ADDR_MASK, 8'hC0);
        rd(ADDR_MASK, 8'h00);
        ev(8'h01);
        chk_irq(1'b0);
        rd(ADDR_STATUS, 8'h20);
        host_u.wr(ADDR_MASK, MASK_RESET);
        ev(8'h01);
        host_u.wr(ADDR_PROTO_CTRL, 8'h80);
        chk_irq(1'b0);
        ev(8'h02);
        rd(ADDR_STATUS, 8'h00);
        host_u.wr(ADDR_PROTO_CTRL, 8'h00);
        ev(8'h02);
        rd(ADDR_STATUS, 8'h10);
        for (int i = 3; i < 5; i++) begin
            ev(8'h01 << i);
            rd(ADDR_STATUS, 8'h04);
        end
        ev(8'h04);
        rd(ADDR_STATUS, 8'h00);
        @(negedge clk) tx_active = 1;
        ev(8'h02);
        chk_irq(1'b0);
        cmp({7'h00, decoder_enable}, 8'h00, "decoder");
        @(negedge clk) tx_active = 0;
        @(negedge clk);
        chk_irq(1'b1);
        cmp({7'h00, decoder_enable}, 8'h01, "decoder");
        rd(ADDR_STATUS, 8'h80);
        mode_type_a = 1;
        @(negedge clk) rx_active = 1;
        ev(8'h04);
        chk_irq(1'b0);
        @(negedge clk) rx_active = 0;
        @(negedge clk);
        chk_irq(1'b1);
        rd(ADDR_STATUS, 8'h48);
        rate_106k = 1;
        for (int i = 0; i < 4; i++) begin
            col_thresh_seven = i[1];
            col_hits = 4'h6 + 4'(i[0]) + 4'(i[1]);
            ev(8'h80);
            rd(ADDR_STATUS, i[0] ? 8'h02 : 8'h00);
        end
        rate_106k = 0;
        ev(8'h20);
        rd(ADDR_STATUS, 8'h02);
        mode_type_a = 0;
        ev(8'h40);
        rd(ADDR_STATUS, 8'h00);
        mode_vicinity = 1;
        host_u.wr(ADDR_MASK, 8'h01);
        ev(8'h40);
        chk_irq(1'b1);
        rd(ADDR_STATUS, 8'h01);
        for (int i = 0; i < 2; i++) begin
            single_subcarrier = i[0];
            ev(8'h20);
            rd(ADDR_STATUS, i[0] ? 8'h02 : 8'h00);
        end
        lfsr = nxt(lfsr);
        @(negedge clk);
        err_pos = lfsr[9:0];
        err_pos_valid = 1;
        @(negedge clk) err_pos_valid = 0;
        rd(ADDR_MASK, {lfsr[9:8], 6'h01});
        rd(ADDR_COL_POS, lfsr[7:0]);
        rd(ADDR_MASK, 8'h01);
        rd(ADDR_COL_POS, 8'h00);
        ev(8'h40);
        chip_en = 0;
        @(negedge clk) chip_en = 1;
        chk_irq(1'b0);
        rd(ADDR_STATUS, STATUS_RESET);
        rd(ADDR_MASK, MASK_RESET);
        repeat (3) @(negedge clk);
        summarize();
    end
endmodule
